//--- design/line_port_ctrl.sv
// Purpose: controller driving the latched control port of line interfaces
// Assumes: several devices share ctl lines, each has its own select
// Notes: select is active low; device latches while selected
//
// What the line interface device does and expects
// RULE_01: three control lines out, two status in
// RULE_02: control code picks exactly one mode
// RULE_03: device latches, bus may move on
// RULE_04: assert only the addressed device's select
// RULE_05: also works point to point
// RULE_06: conversation: hook and ground key status
// RULE_07: feed limit 25, 40 or 60 mA
// RULE_08: test: status shows current at limit
// RULE_09: controller sweeps limits to classify loop; this block leaves the sweep to the user
// RULE_10: ground key filtered about 100 ms
// RULE_11: hook status follows with little delay
// RULE_12: boost battery selectable for long loops
// RULE_13: stand-by reports off-hook on hook line
// RULE_14: device captures only while selected
// RULE_15: device powers up in power down
`timescale 1ns/100ps
`default_nettype none
`include "line_port_params.svh"
module line_port_ctrl (
   input wire logic mclk,
   input wire logic rst_b,
   input wire line_port_pkg::line_cmd_t cmd,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic hook_pin,
   input wire logic gnd_pin,
   output logic [`CTL_W-1:0] ctl_out,
   output logic [`NUM_DEV-1:0] sel_b,
   output line_port_pkg::line_status_t status,
   output logic [1:0] status_dev
);
   // ------------------------------------------------------------
   // status input synchronisers
   // ------------------------------------------------------------
   logic hook_s;
   logic gnd_s;

   line_stat_sync u_hook_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .pin(hook_pin),
      .sync(hook_s)
   );

   line_stat_sync u_gnd_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .pin(gnd_pin),
      .sync(gnd_s)
   );

   // ------------------------------------------------------------
   // command encoder
   // ------------------------------------------------------------
   logic [`CTL_W-1:0] code;

   always_comb begin
      code = `CODE_PDOWN;
      if (cmd.test) begin
         code = `CODE_TEST; // [RULE_08]
      end else if (cmd.boost) begin
         code = `CODE_BOOST; // [RULE_12]
      end else begin
         case (cmd.mode) // [RULE_02]
            line_port_pkg::mode_pdown: code = `CODE_PDOWN;
            line_port_pkg::mode_stby: code = `CODE_STBY;
            line_port_pkg::mode_ring: code = `CODE_RING;
            line_port_pkg::mode_conv: begin
               case (cmd.limit) // [RULE_07]
                  line_port_pkg::lim_40: code = `CODE_CONV_40;
                  line_port_pkg::lim_60: code = `CODE_CONV_60;
                  default: code = `CODE_CONV_25;
               endcase
            end
            default: code = `CODE_PDOWN;
         endcase
      end
   end

   // ------------------------------------------------------------
   // write sequencer
   // ------------------------------------------------------------
   line_port_pkg::wr_state_t st_q;
   line_port_pkg::wr_state_t st_d;
   logic [`CNT_W-1:0] cnt_q;
   logic [`CNT_W-1:0] cnt_d;
   logic [`CTL_W-1:0] ctl_q;
   logic [`CTL_W-1:0] ctl_d;
   logic [`NUM_DEV-1:0] sel_q;
   logic [`NUM_DEV-1:0] sel_d;
   logic [1:0] dev_q;
   logic [1:0] dev_d;
   logic rdy_q;
   logic rdy_d;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ctl_d = ctl_q;
      sel_d = sel_q;
      dev_d = dev_q;
      rdy_d = rdy_q;
      case (st_q)
         line_port_pkg::st_idle: begin
            if (cmd_valid && rdy_q) begin
               ctl_d = code; // [RULE_03]
               dev_d = cmd.dev;
               rdy_d = 1'b0;
               cnt_d = `CNT_W'(`SETUP_CYC - 1);
               st_d = line_port_pkg::st_setup;
            end
         end
         line_port_pkg::st_setup: begin
            if (cnt_q == '0) begin
               sel_d = ~(`NUM_DEV'(1) << dev_q); // [RULE_04] [RULE_14]
               cnt_d = `CNT_W'(`STROBE_CYC - 1);
               st_d = line_port_pkg::st_strobe;
            end else begin
               cnt_d = cnt_q - `CNT_W'(1);
            end
         end
         line_port_pkg::st_strobe: begin
            if (cnt_q == '0) begin
               sel_d = '1;
               cnt_d = `CNT_W'(`HOLD_CYC - 1);
               st_d = line_port_pkg::st_hold;
            end else begin
               cnt_d = cnt_q - `CNT_W'(1);
            end
         end
         line_port_pkg::st_hold: begin
            if (cnt_q == '0) begin
               rdy_d = 1'b1;
               st_d = line_port_pkg::st_idle;
            end else begin
               cnt_d = cnt_q - `CNT_W'(1);
            end
         end
         default: begin
            st_d = line_port_pkg::st_idle;
            sel_d = '1;
            rdy_d = 1'b1;
         end
      endcase
      if (!rst_b) begin
         st_d = line_port_pkg::st_idle;
         cnt_d = '0;
         ctl_d = `CODE_PDOWN; // [RULE_15]
         sel_d = '1;
         dev_d = '0;
         rdy_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ctl_q <= ctl_d;
      sel_q <= sel_d;
      dev_q <= dev_d;
      rdy_q <= rdy_d;
   end

   // ------------------------------------------------------------
   // status capture
   // ------------------------------------------------------------
   line_port_pkg::line_status_t stat_q;
   line_port_pkg::line_status_t stat_d;

   always_comb begin
      stat_d.hook_off = hook_s; // [RULE_06] [RULE_11] [RULE_13]
      stat_d.gnd_key = gnd_s; // [RULE_10]
      if (!rst_b) begin
         stat_d = '0;
      end
   end

   always_ff @(posedge mclk) begin
      stat_q <= stat_d;
   end

   assign ctl_out = ctl_q; // [RULE_01] [RULE_05]
   assign sel_b = sel_q;
   assign cmd_ready = rdy_q;
   assign status = stat_q;
   assign status_dev = dev_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // cycles the current select has been low, for the width checks
   logic [`CNT_W-1:0] low_cnt_q;
   logic [`CNT_W-1:0] low_cnt_d;

   always_comb begin
      low_cnt_d = '0;
      if (rst_b && sel_q != '1) begin
         low_cnt_d = low_cnt_q + `CNT_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      low_cnt_q <= low_cnt_d;
   end

   a_one_select: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_04]
      $countones(~sel_b) <= 1) else $error("more than one select active");
   a_sel_match: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_04]
      (sel_b != '1) |-> (sel_b == ~(`NUM_DEV'(1) << status_dev)))
      else $error("select not of addressed device");
   a_ctl_stable: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_03]
      (sel_b != '1) |-> $stable(ctl_out)) else $error("control moved while selected");
   a_strobe_len: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_14]
      $rose(&sel_b) |-> low_cnt_q == `CNT_W'(`STROBE_CYC)) else $error("select width wrong");
   a_strobe_max: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_14]
      !(&sel_b) |-> low_cnt_q < `CNT_W'(`STROBE_CYC)) else $error("select held too long");
   a_setup_time: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_14]
      $fell(cmd_ready) |-> (&sel_b) [*5] ##1 !(&sel_b))
      else $error("setup time wrong");
   a_ready_back: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_03]
      $rose(&sel_b) |-> ##5 cmd_ready) else $error("ready not back after hold");
   a_conv_code: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_07]
      (cmd_valid && cmd_ready && !cmd.test && !cmd.boost
       && cmd.mode == line_port_pkg::mode_conv && cmd.limit == line_port_pkg::lim_60)
      |=> ctl_out == `CODE_CONV_60) else $error("limit code wrong");
   a_test_code: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_08]
      (cmd_valid && cmd_ready && cmd.test) |=> ctl_out == `CODE_TEST)
      else $error("test code wrong");
   a_boost_code: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_12]
      (cmd_valid && cmd_ready && !cmd.test && cmd.boost) |=> ctl_out == `CODE_BOOST)
      else $error("boost code wrong");
   a_hook_lat: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE_11]
      $rose(hook_pin) ##1 hook_pin [*2] |=> status.hook_off)
      else $error("hook status late");
   a_reset_pd: assert property (@(posedge mclk) // [RULE_15]
      !rst_b |=> ctl_out == `CODE_PDOWN && sel_b == '1 && status == '0)
      else $error("reset state wrong");

   c_write: cover property (@(posedge mclk) disable iff (!rst_b) $rose(cmd_ready));
   c_ring: cover property (@(posedge mclk) disable iff (!rst_b) ctl_out == `CODE_RING && !(&sel_b));
   c_test: cover property (@(posedge mclk) disable iff (!rst_b) ctl_out == `CODE_TEST && status.hook_off);
   c_gnd: cover property (@(posedge mclk) disable iff (!rst_b) status.gnd_key);
endmodule : line_port_ctrl
`default_nettype wire

//--- design/line_port_params.svh
// Purpose: constants for the line interface control port controller
// Assumes: 125 MHz mclk
// Notes: code points of the three control lines are a controller-side choice
`ifndef LINE_PORT_PARAMS_SVH
`define LINE_PORT_PARAMS_SVH

`define CLK_PERIOD_NS 8
// setup of data before select, select width, hold after select (ns)
`define SETUP_NS 40
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_NS 80
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_NS 40
`define HOLD_CYC ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 4

`define NUM_DEV 4
`define DEV_W 2
`define CTL_W 3

// control line code points
`define CODE_PDOWN 3'h0
`define CODE_STBY 3'h1
`define CODE_CONV_25 3'h2
`define CODE_CONV_40 3'h3
`define CODE_CONV_60 3'h4
`define CODE_RING 3'h5
`define CODE_BOOST 3'h6
`define CODE_TEST 3'h7

`endif

//--- design/line_port_pkg.sv
// Purpose: types for the line interface control port controller
// Assumes: constants in line_port_params.svh
// Notes: none
`default_nettype none
package line_port_pkg;

   typedef enum logic [1:0] {
      mode_pdown = 2'h0,
      mode_stby = 2'h1,
      mode_conv = 2'h2,
      mode_ring = 2'h3
   } line_mode_t;

   typedef enum logic [1:0] {
      lim_25 = 2'h0,
      lim_40 = 2'h1,
      lim_60 = 2'h2
   } feed_limit_t;

   typedef struct packed {
      logic [1:0] dev;
      line_mode_t mode;
      feed_limit_t limit;
      logic boost;
      logic test;
   } line_cmd_t;

   typedef struct packed {
      logic hook_off;
      logic gnd_key;
   } line_status_t;

   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_setup = 4'h2,
      st_strobe = 4'h4,
      st_hold = 4'h8
   } wr_state_t;

endpackage : line_port_pkg
`default_nettype wire

//--- design/line_stat_sync.sv
// Purpose: two-flop synchroniser for one status line
// Assumes: input is asynchronous to mclk
// Notes: first flop is read only by the second
`timescale 1ns/100ps
`default_nettype none
module line_stat_sync (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic pin,
   output logic sync
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb begin
      meta_d = pin;
      sync_d = meta_q;
      if (!rst_b) begin
         meta_d = 1'b0;
         sync_d = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
   end

   assign sync = sync_q;
endmodule : line_stat_sync
`default_nettype wire

//--- verification/line_dev_model.sv
// Purpose: behavioural line interface device seen through its latched control port
// Assumes: select lines active low, one status pair routed out by watch
// Notes: line conditions come from the bench; ground key filter not modelled
`timescale 1ns/100ps
`default_nettype none
`include "line_port_params.svh"
module line_dev_model (
   input wire logic [`NUM_DEV-1:0] sel_b,
   input wire logic [`CTL_W-1:0] ctl,
   input wire logic [1:0] watch,
   input wire logic off_hook,
   input wire logic gnd_key,
   input wire logic at_limit,
   output logic hook_pin,
   output logic gnd_pin
);
   logic [`CTL_W-1:0] lat_q [`NUM_DEV];
   logic [`CTL_W-1:0] cur;
   // ------------------------------
   // control latches
   // ------------------------------
   // one process owns the latches: power-up value, then capture while selected
   initial begin
      for (int d = 0; d < `NUM_DEV; d++) lat_q[d] = `CODE_PDOWN;
      forever begin
         @(sel_b or ctl);
         for (int d = 0; d < `NUM_DEV; d++) begin
            if (sel_b[d] === 1'b0) lat_q[d] = ctl;
         end
      end
   end
   // ------------------------------
   // status lines
   // ------------------------------
   always @* begin
      cur = lat_q[watch];
      hook_pin = 1'b0;
      gnd_pin = 1'b0;
      case (cur)
         `CODE_STBY: hook_pin = off_hook;
         `CODE_CONV_25, `CODE_CONV_40, `CODE_CONV_60, `CODE_BOOST: begin
            hook_pin = off_hook;
            gnd_pin = gnd_key;
         end
         `CODE_TEST: hook_pin = at_limit;
         default: ;
      endcase
   end
endmodule : line_dev_model
`default_nettype wire

//--- verification/test_line_port_ctrl.sv
// Purpose: self-checking bench for the line port controller
// Assumes: one device model holds the latches of all four lines
// Notes: limit sweep is a user sequence, exercised here by t_sweep
`timescale 1ns/100ps
`default_nettype none
`include "line_port_params.svh"
module test_line_port_ctrl;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   line_port_pkg::line_cmd_t cmd = '0;
   logic cmd_valid = 1'b0;
   logic off_hook = 1'b0;
   logic gnd_key = 1'b0;
   logic at_limit = 1'b0;
   logic [1:0] watch = 2'h1;
   logic cmd_ready;
   logic hook_pin;
   logic gnd_pin;
   logic [`CTL_W-1:0] ctl_out;
   logic [`NUM_DEV-1:0] sel_b;
   line_port_pkg::line_status_t status;
   logic [1:0] status_dev;
   int miscompares = 0;
   int tests_run = 0;
   always #4 mclk = ~mclk;
   line_port_ctrl dut (.mclk(mclk), .rst_b(rst_b), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .hook_pin(hook_pin), .gnd_pin(gnd_pin), .ctl_out(ctl_out), .sel_b(sel_b), .status(status),
      .status_dev(status_dev));
   line_dev_model model (.sel_b(sel_b), .ctl(ctl_out), .watch(watch), .off_hook(off_hook),
      .gnd_key(gnd_key), .at_limit(at_limit), .hook_pin(hook_pin), .gnd_pin(gnd_pin));
   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("comparisons=%0d mismatches=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   // one command: code, select window of 10 cycles, ready seen 20 edges after the take
   task automatic send(input logic [1:0] dev, input logic [1:0] md, input logic [1:0] lim,
      input logic bst, input logic tst, input logic [2:0] code);
      int low;
      int rdy;
      low = 0;
      rdy = 0;
      @(posedge mclk);
      cmd <= '{dev, line_port_pkg::line_mode_t'(md), line_port_pkg::feed_limit_t'(lim), bst, tst};
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      for (int i = 1; i <= 22; i++) begin
         @(posedge mclk);
         #1;
         if (i == 1) begin
            chk(8'(ctl_out), 8'(code));
            chk(8'(status_dev), 8'(dev));
         end
         if (sel_b === ~(4'h1 << dev)) low++;
         else chk(8'(sel_b), 8'hff >> 4);
         if (cmd_ready === 1'b1 && rdy == 0) rdy = i;
      end
      chk(8'(low), 8'h0a);
      chk(8'(rdy), 8'h14);
      chk(8'(model.lat_q[dev]), 8'(code));
   endtask : send
   // status pins seen after three edges, not two
   task automatic pin_lag(input logic hk, input logic gk, input logic [1:0] prev, input logic [1:0] exp);
      @(posedge mclk);
      off_hook <= hk;
      gnd_key <= gk;
      repeat (2) @(posedge mclk);
      #1;
      chk(8'(status), 8'(prev));
      @(posedge mclk);
      #1;
      chk(8'(status), 8'(exp));
   endtask : pin_lag
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_modes();
      send(2'h0, 2'h1, 2'h0, 1'b0, 1'b0, 3'h1);
      send(2'h1, 2'h2, 2'h0, 1'b0, 1'b0, 3'h2);
      send(2'h2, 2'h2, 2'h1, 1'b0, 1'b0, 3'h3);
      send(2'h3, 2'h2, 2'h2, 1'b0, 1'b0, 3'h4);
      send(2'h0, 2'h3, 2'h0, 1'b0, 1'b0, 3'h5);
      send(2'h1, 2'h2, 2'h0, 1'b1, 1'b0, 3'h6);
      send(2'h2, 2'h2, 2'h0, 1'b1, 1'b1, 3'h7);
      send(2'h3, 2'h0, 2'h0, 1'b0, 1'b0, 3'h0);
      send(2'h0, 2'h2, 2'h3, 1'b0, 1'b0, 3'h2);
      chk(8'(model.lat_q[1]), 8'h06);
      chk(8'(model.lat_q[2]), 8'h07);
      chk(8'(model.lat_q[3]), 8'h00);
      $display("test modes done");
   endtask : t_modes
   task automatic t_status();
      send(2'h1, 2'h2, 2'h1, 1'b0, 1'b0, 3'h3);
      pin_lag(1'b1, 1'b1, 2'h0, 2'h3);
      pin_lag(1'b0, 1'b0, 2'h3, 2'h0);
      send(2'h1, 2'h1, 2'h0, 1'b0, 1'b0, 3'h1);
      pin_lag(1'b1, 1'b1, 2'h0, 2'h2);
      chk(8'(status), 8'h02);
      send(2'h1, 2'h2, 2'h0, 1'b0, 1'b1, 3'h7);
      chk(8'(status), 8'h00);
      @(posedge mclk);
      at_limit <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      chk(8'(status), 8'h02);
      send(2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 3'h0);
      chk(8'(status), 8'h00);
      $display("test status done");
   endtask : t_status
   // line length sweep: set each limit, then test; only the 60 mA step reads below limit
   task automatic t_sweep();
      for (int l = 0; l < 3; l++) begin
         send(2'h1, 2'h2, 2'(l), 1'b0, 1'b0, 3'(2 + l));
         @(posedge mclk);
         at_limit <= (l != 2);
         send(2'h1, 2'h2, 2'(l), 1'b0, 1'b1, 3'h7);
         chk(8'(status), 8'((l != 2) ? 2 : 0));
      end
      $display("test sweep done");
   endtask : t_sweep
   initial begin
      #20000;
      miscompares++;
      test_done();
   end
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      chk(8'({ctl_out, sel_b, cmd_ready}), 8'h1f);
      chk(8'(model.lat_q[0]), 8'h00);
      $display("test reset done");
      t_modes();
      t_status();
      t_sweep();
      test_done();
   end
endmodule : test_line_port_ctrl
`default_nettype wire
